// ### include/panel_pkg.sv
// constants and types shared by the front-panel menu controller
package panel_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned DUAL_HOLD_MS    = 1000;
  localparam int unsigned IDLE_EXIT_S     = 60;
  localparam int unsigned FREQ_DETECT_S   = 5;
  localparam int unsigned LONG_PRESS_MS   = 500;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned DUAL_HOLD_CYC   = CLK_HZ / 1000 * DUAL_HOLD_MS;
  localparam int unsigned IDLE_EXIT_CYC   = CLK_HZ * IDLE_EXIT_S;
  localparam int unsigned FREQ_DETECT_CYC = CLK_HZ * FREQ_DETECT_S;
  localparam int unsigned LONG_PRESS_CYC  = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned ROT_UNIT_CYC    = CLK_HZ;
  localparam int unsigned DIGITS          = 3;
  localparam int unsigned BYTES           = 4;
  localparam logic [11:0] CT_PRI_RESET    = 12'h005;
  localparam logic        CT_SEC_RESET    = 1'b1;
  localparam logic [11:0] VT_PRI_RESET    = 12'h400;
  localparam logic [11:0] VT_SEC_RESET    = 12'h400;
  localparam logic [1:0]  DP_RESET        = 2'h0;
  localparam logic [1:0]  DIG_ALL         = 2'h3;
  localparam logic [3:0]  DIG_MAX         = 4'h9;

  typedef enum logic [1:0] {MODE_DISPLAY, MODE_PASSWORD, MODE_PROGRAM} mode_t;
  typedef enum logic [2:0] {
    MENU_CT, MENU_VT, MENU_PARAM, MENU_ADDR, MENU_SUBNET, MENU_GATEWAY, MENU_DYN
  } menu_t;
  typedef enum logic [2:0] {
    FLD_NONE, FLD_PRI, FLD_SEC, FLD_PADDR, FLD_PVAL, FLD_BYTE, FLD_FLAG
  } field_t;
endpackage : panel_pkg

// ### src/button_conditioner.sv
// synchroniser, debouncer and press classifier for the two buttons
`timescale 1ns/1ps
`default_nettype none
module button_conditioner
  import panel_pkg::*;
#(
  parameter int unsigned DEBOUNCE = DEBOUNCE_CYC,
  parameter int unsigned LONG     = LONG_PRESS_CYC,
  parameter int unsigned DUAL     = DUAL_HOLD_CYC
) (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  // raw buttons, high while pressed
  input  wire logic [1:0] button_raw_in,
  // classified events
  output logic [1:0]      short_press_out,
  output logic [1:0]      long_press_out,
  output logic            dual_hold_out,
  output logic            any_press_out
);
  initial begin
    if (DEBOUNCE < 1 || LONG <= DEBOUNCE || DUAL < 1 || DUAL >= 2**24 || LONG >= 2**24)
      $error("button_conditioner: bad thresholds");
  end

  typedef struct packed {
    logic [1:0]      meta;
    logic [1:0]      sync;
    logic [1:0]      stable;
    logic [1:0][23:0] bounce;
    logic [1:0][23:0] held;
    logic [1:0]      long_done;
    logic [23:0]     dual_cnt;
    logic            dual_done;
    logic [1:0]      short_p;
    logic [1:0]      long_p;
    logic            dual_p;
  } cond_t;

  cond_t st_ff;
  cond_t nxt_st;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.meta    = button_raw_in;
    nxt_st.sync    = st_ff.meta;
    nxt_st.short_p = 2'h0;
    nxt_st.long_p  = 2'h0;
    nxt_st.dual_p  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // debounce: accept a level that stays stable long enough
      if (st_ff.sync[i] == st_ff.stable[i]) begin
        nxt_st.bounce[i] = 24'h0;
      end else if (st_ff.bounce[i] == 24'(DEBOUNCE - 1)) begin
        nxt_st.bounce[i] = 24'h0;
        nxt_st.stable[i] = st_ff.sync[i];
      end else begin
        nxt_st.bounce[i] = st_ff.bounce[i] + 24'h1;
      end
      if (st_ff.stable[i]) begin
        if (st_ff.held[i] != 24'hFFFFFF)
          nxt_st.held[i] = st_ff.held[i] + 24'h1;
        if (st_ff.held[i] == 24'(LONG) && !st_ff.dual_done && !(&st_ff.stable)) begin
          nxt_st.long_p[i]    = 1'b1;
          nxt_st.long_done[i] = 1'b1;
        end
      end else begin
        nxt_st.held[i]      = 24'h0;
        nxt_st.long_done[i] = 1'b0;
        if (st_ff.held[i] != 24'h0 && !st_ff.long_done[i] && !st_ff.dual_done
            && !st_ff.stable[~i[0]])
          nxt_st.short_p[i] = 1'b1;
      end
    end
    // both buttons together for the dual-hold time
    if (&st_ff.stable) begin
      if (st_ff.dual_cnt == 24'(DUAL - 1) && !st_ff.dual_done) begin
        nxt_st.dual_p    = 1'b1;
        nxt_st.dual_done = 1'b1;
      end else if (!st_ff.dual_done) begin
        nxt_st.dual_cnt = st_ff.dual_cnt + 24'h1;
      end
    end else begin
      nxt_st.dual_cnt = 24'h0;
      if (~|st_ff.stable)
        nxt_st.dual_done = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign short_press_out = st_ff.short_p;
  assign long_press_out  = st_ff.long_p;
  assign dual_hold_out   = st_ff.dual_p;
  assign any_press_out   = |(st_ff.stable & ~st_ff.sync) | (|(~st_ff.stable & st_ff.sync));
endmodule : button_conditioner
`default_nettype wire

// ### src/front_panel_menu_control.sv
// front-panel mode machine: display, password and programming menus
// Function
// - dual one-second hold enters programming after password
// - no stored password skips the query
// - programming indicator shown while programming
// - button two advances menus in fixed order
// - leave programming on idle timeout or dual-hold
// - display mode steps indications, three quantities each
// - rotation steps indications at set interval
// - values limited to three significant digits
// - current ratio resets to five over five
// - secondary current only one or five amperes
// - password starts zero, first digit flashing, must match
// - confirming transformer menu flashes first primary digit
// - button two edits digit, shifts point when all
// - parameter list edits address then value
// - profiles and clock not editable from buttons
// - one common ratio per phase group
// - accuracy flag held low first five seconds
// - short press steps forward, long press back
// - edits applied only on leaving programming; parameter values written on confirm
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module front_panel_menu_control
  import panel_pkg::*;
#(
  parameter int unsigned IDLE_CYC   = IDLE_EXIT_CYC,
  parameter int unsigned FREQ_CYC   = FREQ_DETECT_CYC,
  parameter int unsigned ROT_UNIT   = ROT_UNIT_CYC,
  parameter int unsigned DUAL_CYC   = DUAL_HOLD_CYC,
  parameter int unsigned LONG_CYC   = LONG_PRESS_CYC,
  parameter int unsigned BOUNCE_CYC = DEBOUNCE_CYC,
  parameter int unsigned IND_COUNT  = 8
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // front-panel buttons, high while pressed
  input  wire logic [1:0]  button_raw_in,
  // stored settings from the rest of the device
  input  wire logic        password_set_in,
  input  wire logic [11:0] password_code_in,
  input  wire logic        rotation_enable_in,
  input  wire logic [7:0]  rotation_time_in,
  // parameter list access
  output logic [11:0]      param_addr_out,
  input  wire logic [11:0] param_rdata_in,
  output logic [11:0]      param_wdata_out,
  output logic             param_write_out,
  // display state
  output logic             programming_indicator_out,
  output logic             password_query_out,
  output logic [2:0]       menu_out,
  output logic [2:0]       field_out,
  output logic [1:0]       digit_sel_out,
  output logic [11:0]      edit_value_out,
  output logic [1:0]       decimal_point_out,
  output logic [7:0]       indication_out,
  // applied settings
  output logic [11:0]      ct_primary_out,
  output logic [1:0]       ct_primary_dp_out,
  output logic             ct_secondary_5a_out,
  output logic [11:0]      vt_primary_out,
  output logic [11:0]      vt_secondary_out,
  output logic [3:0][7:0]  ip_addr_out,
  output logic [3:0][7:0]  subnet_out,
  output logic [3:0][7:0]  gateway_out,
  output logic             dyn_ip_out,
  output logic             settings_apply_out,
  output logic             accuracy_valid_out
);
  initial begin
    if (IDLE_CYC < 1 || IDLE_CYC >= 2**30 || FREQ_CYC < 1 || FREQ_CYC >= 2**30
        || ROT_UNIT < 1 || ROT_UNIT >= 2**30 || IND_COUNT < 2 || IND_COUNT > 256)
      $error("front_panel_menu_control: bad parameters");
  end

  typedef struct packed {
    logic [11:0]     pri;
    logic [1:0]      dp;
    logic [11:0]     sec;
    logic            sec5;
  } ratio_t;

  typedef struct packed {
    mode_t           mode;
    menu_t           menu;
    field_t          field;
    logic [1:0]      dig;
    logic [1:0]      byte_idx;
    logic [11:0]     pw;
    logic [11:0]     paddr;
    logic [11:0]     pval;
    logic            pwrite;
    ratio_t          ct_e;
    ratio_t          vt_e;
    logic [3:0][7:0] ip_e;
    logic [3:0][7:0] sn_e;
    logic [3:0][7:0] gw_e;
    logic            dyn_e;
    ratio_t          ct;
    ratio_t          vt;
    logic [3:0][7:0] ip;
    logic [3:0][7:0] sn;
    logic [3:0][7:0] gw;
    logic            dyn;
    logic            apply;
    logic [29:0]     idle;
    logic [29:0]     freq;
    logic            valid;
    logic [29:0]     rot_unit;
    logic [7:0]      rot_cnt;
    logic [7:0]      ind;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [1:0] short_p;
  logic [1:0] long_p;
  logic       dual_p;
  logic       any_p;

  button_conditioner #(
    .DEBOUNCE (BOUNCE_CYC),
    .LONG     (LONG_CYC),
    .DUAL     (DUAL_CYC)
  ) u_buttons (
    .clock_in        (clock_in),
    .reset_n_in      (reset_n_in),
    .button_raw_in   (button_raw_in),
    .short_press_out (short_p),
    .long_press_out  (long_p),
    .dual_hold_out   (dual_p),
    .any_press_out   (any_p)
  );

  // step one bcd digit of a three-digit value forward or back
  function automatic logic [11:0] step_digit(input logic [11:0] v, input logic [1:0] d,
                                             input logic up);
    logic [3:0]  n;
    logic [11:0] r;
    r = v;
    n = v[4*(2-d) +: 4];
    if (up)
      n = (n >= DIG_MAX) ? 4'h0 : n + 4'h1;
    else
      n = (n == 4'h0) ? DIG_MAX : n - 4'h1;
    r[4*(2-d) +: 4] = n;
    return r;
  endfunction : step_digit

  // digit index wraps over the three digits plus the whole-number slot
  function automatic logic [1:0] next_dig(input logic [1:0] d, input logic with_all);
    if (d == 2'h2)
      return with_all ? DIG_ALL : 2'h0;
    else if (d == DIG_ALL)
      return 2'h0;
    else
      return d + 2'h1;
  endfunction : next_dig

  // step a byte by one
  function automatic logic [7:0] step_byte(input logic [7:0] b, input logic up);
    return up ? b + 8'h01 : b - 8'h01;
  endfunction : step_byte

  logic b1;
  logic b2;
  logic up2;
  assign b1  = short_p[0] | long_p[0];
  assign b2  = short_p[1] | long_p[1];
  assign up2 = short_p[1];

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.pwrite = 1'b0;
    nxt_st.apply  = 1'b0;
    // accuracy not guaranteed until frequency detection settles
    if (!st_ff.valid) begin
      if (st_ff.freq == 30'(FREQ_CYC - 1))
        nxt_st.valid = 1'b1;
      else
        nxt_st.freq = st_ff.freq + 30'h1;
    end
    unique case (st_ff.mode)
      MODE_DISPLAY: begin
        // step indications; each holds up to three quantities downstream
        if (short_p[0] | short_p[1])
          nxt_st.ind = (st_ff.ind == 8'(IND_COUNT - 1)) ? 8'h00 : st_ff.ind + 8'h01;
        else if (long_p[0] | long_p[1])
          nxt_st.ind = (st_ff.ind == 8'h00) ? 8'(IND_COUNT - 1) : st_ff.ind - 8'h01;
        // rotation through indications
        if (rotation_enable_in && !any_p) begin
          if (st_ff.rot_unit == 30'(ROT_UNIT - 1)) begin
            nxt_st.rot_unit = 30'h0;
            if (st_ff.rot_cnt + 8'h01 >= rotation_time_in) begin
              nxt_st.rot_cnt = 8'h00;
              nxt_st.ind = (st_ff.ind == 8'(IND_COUNT - 1)) ? 8'h00 : st_ff.ind + 8'h01;
            end else begin
              nxt_st.rot_cnt = st_ff.rot_cnt + 8'h01;
            end
          end else begin
            nxt_st.rot_unit = st_ff.rot_unit + 30'h1;
          end
        end else begin
          nxt_st.rot_unit = 30'h0;
          nxt_st.rot_cnt  = 8'h00;
        end
        if (dual_p) begin
          // edit copies start from the applied values
          nxt_st.ct_e  = st_ff.ct;
          nxt_st.vt_e  = st_ff.vt;
          nxt_st.ip_e  = st_ff.ip;
          nxt_st.sn_e  = st_ff.sn;
          nxt_st.gw_e  = st_ff.gw;
          nxt_st.dyn_e = st_ff.dyn;
          nxt_st.menu  = MENU_CT;
          nxt_st.field = FLD_NONE;
          nxt_st.idle  = 30'h0;
          nxt_st.dig   = 2'h0;
          nxt_st.pw    = 12'h000;
          nxt_st.mode  = password_set_in ? MODE_PASSWORD : MODE_PROGRAM;
        end
      end
      MODE_PASSWORD: begin
        if (any_p)
          nxt_st.idle = 30'h0;
        else if (st_ff.idle != 30'(IDLE_CYC - 1))
          nxt_st.idle = st_ff.idle + 30'h1;
        if (dual_p || st_ff.idle == 30'(IDLE_CYC - 1)) begin
          nxt_st.mode = MODE_DISPLAY;
        end else if (b2) begin
          nxt_st.pw = step_digit(st_ff.pw, st_ff.dig, up2);
        end else if (b1) begin
          if (st_ff.dig == 2'h2) begin
            nxt_st.dig = 2'h0;
            if (st_ff.pw == password_code_in)
              nxt_st.mode = MODE_PROGRAM;
            else
              nxt_st.pw = 12'h000;
          end else begin
            nxt_st.dig = st_ff.dig + 2'h1;
          end
        end
      end
      MODE_PROGRAM: begin
        if (any_p)
          nxt_st.idle = 30'h0;
        else if (st_ff.idle != 30'(IDLE_CYC - 1))
          nxt_st.idle = st_ff.idle + 30'h1;
        if (dual_p || st_ff.idle == 30'(IDLE_CYC - 1)) begin
          // commit edit copies only on exit
          nxt_st.mode  = MODE_DISPLAY;
          nxt_st.field = FLD_NONE;
          nxt_st.ct    = st_ff.ct_e;
          nxt_st.vt    = st_ff.vt_e;
          nxt_st.ip    = st_ff.ip_e;
          nxt_st.sn    = st_ff.sn_e;
          nxt_st.gw    = st_ff.gw_e;
          nxt_st.dyn   = st_ff.dyn_e;
          nxt_st.apply = 1'b1;
        end else if (st_ff.field == FLD_NONE) begin
          if (b2) begin
            // menu order; profiles and clock are never offered
            if (up2)
              nxt_st.menu = (st_ff.menu == MENU_DYN) ? MENU_CT : menu_t'(st_ff.menu + 3'h1);
            else
              nxt_st.menu = (st_ff.menu == MENU_CT) ? MENU_DYN : menu_t'(st_ff.menu - 3'h1);
          end else if (b1) begin
            nxt_st.dig      = 2'h0;
            nxt_st.byte_idx = 2'h0;
            unique case (st_ff.menu)
              MENU_CT, MENU_VT: nxt_st.field = FLD_PRI;
              MENU_PARAM: begin
                nxt_st.field = FLD_PADDR;
                nxt_st.pval  = param_rdata_in;
              end
              MENU_DYN: nxt_st.field = FLD_FLAG;
              default: nxt_st.field = FLD_BYTE;
            endcase
          end
        end else begin
          unique case (st_ff.field)
            FLD_PRI: begin
              // one ratio for the phase group; three digits only
              if (b2) begin
                if (st_ff.dig == DIG_ALL) begin
                  if (st_ff.menu == MENU_CT)
                    nxt_st.ct_e.dp = st_ff.ct_e.dp + 2'h1;
                  else
                    nxt_st.vt_e.dp = st_ff.vt_e.dp + 2'h1;
                end else if (st_ff.menu == MENU_CT) begin
                  nxt_st.ct_e.pri = step_digit(st_ff.ct_e.pri, st_ff.dig, up2);
                end else begin
                  nxt_st.vt_e.pri = step_digit(st_ff.vt_e.pri, st_ff.dig, up2);
                end
              end else if (b1) begin
                if (st_ff.dig == DIG_ALL) begin
                  nxt_st.field = FLD_SEC;
                  nxt_st.dig   = 2'h0;
                end else begin
                  nxt_st.dig = next_dig(st_ff.dig, 1'b1);
                end
              end
            end
            FLD_SEC: begin
              if (b2) begin
                if (st_ff.menu == MENU_CT)
                  nxt_st.ct_e.sec5 = ~st_ff.ct_e.sec5;
                else
                  nxt_st.vt_e.sec = step_digit(st_ff.vt_e.sec, st_ff.dig, up2);
              end else if (b1) begin
                if (st_ff.menu == MENU_CT || st_ff.dig == 2'h2)
                  nxt_st.field = FLD_NONE;
                else
                  nxt_st.dig = st_ff.dig + 2'h1;
              end
            end
            FLD_PADDR: begin
              if (b2) begin
                nxt_st.paddr = step_digit(st_ff.paddr, st_ff.dig, up2);
              end else if (b1) begin
                if (st_ff.dig == 2'h2) begin
                  nxt_st.field = FLD_PVAL;
                  nxt_st.dig   = 2'h0;
                  nxt_st.pval  = param_rdata_in;
                end else begin
                  nxt_st.dig = st_ff.dig + 2'h1;
                end
              end
            end
            FLD_PVAL: begin
              if (b2) begin
                nxt_st.pval = step_digit(st_ff.pval, st_ff.dig, up2);
              end else if (b1) begin
                if (st_ff.dig == 2'h2) begin
                  nxt_st.field  = FLD_NONE;
                  nxt_st.dig    = 2'h0;
                  nxt_st.pwrite = 1'b1;
                end else begin
                  nxt_st.dig = st_ff.dig + 2'h1;
                end
              end
            end
            FLD_BYTE: begin
              if (b2) begin
                unique case (st_ff.menu)
                  MENU_ADDR:
                    nxt_st.ip_e[st_ff.byte_idx] = step_byte(st_ff.ip_e[st_ff.byte_idx], up2);
                  MENU_SUBNET:
                    nxt_st.sn_e[st_ff.byte_idx] = step_byte(st_ff.sn_e[st_ff.byte_idx], up2);
                  default:
                    nxt_st.gw_e[st_ff.byte_idx] = step_byte(st_ff.gw_e[st_ff.byte_idx], up2);
                endcase
              end else if (b1) begin
                if (st_ff.byte_idx == 2'(BYTES - 1))
                  nxt_st.field = FLD_NONE;
                else
                  nxt_st.byte_idx = st_ff.byte_idx + 2'h1;
              end
            end
            FLD_FLAG: begin
              if (b2)
                nxt_st.dyn_e = ~st_ff.dyn_e;
              else if (b1)
                nxt_st.field = FLD_NONE;
            end
            default: nxt_st.field = FLD_NONE;
          endcase
        end
      end
      default: nxt_st.mode = MODE_DISPLAY;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_ff          <= '0;
      st_ff.ct.pri   <= CT_PRI_RESET;
      st_ff.ct.sec5  <= CT_SEC_RESET;
      st_ff.ct.dp    <= DP_RESET;
      st_ff.vt.pri   <= VT_PRI_RESET;
      st_ff.vt.sec   <= VT_SEC_RESET;
      st_ff.dyn      <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign param_addr_out            = st_ff.paddr;
  assign param_wdata_out           = st_ff.pval;
  assign param_write_out           = st_ff.pwrite;
  assign programming_indicator_out = (st_ff.mode == MODE_PROGRAM);
  assign password_query_out        = (st_ff.mode == MODE_PASSWORD);
  assign menu_out                  = st_ff.menu;
  assign field_out                 = st_ff.field;
  assign digit_sel_out             = (st_ff.field == FLD_BYTE) ? st_ff.byte_idx : st_ff.dig;
  assign edit_value_out            = (st_ff.mode == MODE_PASSWORD) ? st_ff.pw : st_ff.pval;
  assign decimal_point_out         = (st_ff.menu == MENU_VT) ? st_ff.vt_e.dp : st_ff.ct_e.dp;
  assign indication_out            = st_ff.ind;
  assign ct_primary_out            = st_ff.ct.pri;
  assign ct_primary_dp_out         = st_ff.ct.dp;
  assign ct_secondary_5a_out       = st_ff.ct.sec5;
  assign vt_primary_out            = st_ff.vt.pri;
  assign vt_secondary_out          = st_ff.vt.sec;
  assign ip_addr_out               = st_ff.ip;
  assign subnet_out                = st_ff.sn;
  assign gateway_out               = st_ff.gw;
  assign dyn_ip_out                = st_ff.dyn;
  assign settings_apply_out        = st_ff.apply;
  assign accuracy_valid_out        = st_ff.valid;
endmodule : front_panel_menu_control
`default_nettype wire

// ### verif/operator_model.sv
// model of the operator pressing the two front-panel buttons
`timescale 1ns/1ps
`default_nettype none
module operator_model (
  // clock
  input  wire logic      clock_in,
  // buttons toward the block
  output var logic [1:0] button_raw_out
);
  initial button_raw_out = 2'h0;
  // hold, release, let events land
  task automatic press(input logic [1:0] mask, input int hold);
    @(posedge clock_in) button_raw_out <= mask;
    repeat (hold) @(posedge clock_in);
    button_raw_out <= 2'h0;
    repeat (30) @(posedge clock_in);
  endtask : press
  // only the decimal point is stepped, never a zero primary current
endmodule : operator_model
`default_nettype wire

// ### verif/panel_checker_asserts.sv
// concurrent checks on the front-panel menu controller ports
`timescale 1ns/1ps
`default_nettype none
module panel_checker
  import panel_pkg::*;
#(
  parameter int unsigned FREQ_CYC = FREQ_DETECT_CYC
) (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  // watched signals
  input wire logic        password_set_in,
  input wire logic        programming_indicator_out,
  input wire logic        password_query_out,
  input wire logic [2:0]  menu_out,
  input wire logic [1:0]  digit_sel_out,
  input wire logic [11:0] edit_value_out,
  input wire logic        param_write_out,
  input wire logic [11:0] ct_primary_out,
  input wire logic        ct_secondary_5a_out,
  input wire logic        settings_apply_out,
  input wire logic        accuracy_valid_out
);
  logic [31:0] up_ff;
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) up_ff <= 32'h0;
    else if (up_ff != 32'hFFFFFFFF) up_ff <= up_ff + 32'h1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  a_reset_ct_ratio: assert property ($rose(reset_n_in) |->
    ct_primary_out == CT_PRI_RESET && ct_secondary_5a_out) else $error("ct reset wrong");
  a_accuracy_early: assert property (up_ff + 2 < FREQ_CYC |-> !accuracy_valid_out)
    else $error("accuracy too early");
  a_accuracy_late: assert property (up_ff > FREQ_CYC + 2 |-> accuracy_valid_out)
    else $error("accuracy too late");
  a_apply_on_exit: assert property ($fell(programming_indicator_out) |-> ##[0:1]
    settings_apply_out) else $error("no apply on exit");
  a_commit_only_apply: assert property ($changed(ct_secondary_5a_out) |->
    settings_apply_out || $past(settings_apply_out)) else $error("early commit");
  a_write_param_menu: assert property (param_write_out |->
    programming_indicator_out && menu_out == MENU_PARAM) else $error("stray write");
  a_pw_start_zero: assert property ($rose(password_query_out) |-> $past(password_set_in)
    && edit_value_out == 12'h000 && digit_sel_out == 2'h0) else $error("bad query start");
  a_pw_not_prog: assert property (password_query_out |-> !programming_indicator_out)
    else $error("query while programming");
  a_pw_digit_bcd: assert property (password_query_out |-> edit_value_out[11:8] <= DIG_MAX
    && edit_value_out[7:4] <= DIG_MAX && edit_value_out[3:0] <= DIG_MAX)
    else $error("digit above nine");
endmodule : panel_checker
bind front_panel_menu_control panel_checker #(.FREQ_CYC(FREQ_CYC)) chk_inst (.*);
`default_nettype wire

// ### verif/front_panel_menu_control_tb.sv
// self-checking bench for the front-panel menu controller
`timescale 1ns/1ps
`default_nettype none
module front_panel_menu_control_tb;
  import panel_pkg::*;
  localparam int unsigned IDLE = 2000;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [1:0]  button_raw;
  logic        password_set = 1'b0;
  logic        rot_en = 1'b0;
  logic        prog, pwq, sec5, dyn, acc, pwr;
  logic [2:0]  menu, field;
  logic [1:0]  dig, dp, ct_dp;
  logic [7:0]  ind;
  logic [11:0] edit, ct_pri, vt_pri, vt_sec, paddr, pwd;
  int          fail_count = 0;
  int          checks = 0;
  int          writes = 0;
  always #50 clock_in = ~clock_in;
  always @(posedge clock_in) writes <= writes + pwr;
  operator_model op (.clock_in(clock_in), .button_raw_out(button_raw));
  front_panel_menu_control #(.IDLE_CYC(IDLE), .FREQ_CYC(500), .ROT_UNIT(50), .DUAL_CYC(100),
    .LONG_CYC(60), .BOUNCE_CYC(4)) DUT (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .button_raw_in(button_raw), .password_set_in(password_set), .password_code_in(12'h100),
    .rotation_enable_in(rot_en), .rotation_time_in(8'h02), .param_addr_out(paddr),
    .param_rdata_in(paddr), .param_wdata_out(pwd), .param_write_out(pwr),
    .programming_indicator_out(prog), .password_query_out(pwq), .menu_out(menu),
    .field_out(field), .digit_sel_out(dig), .edit_value_out(edit), .decimal_point_out(dp),
    .indication_out(ind), .ct_primary_out(ct_pri), .ct_primary_dp_out(ct_dp),
    .ct_secondary_5a_out(sec5), .vt_primary_out(vt_pri), .vt_secondary_out(vt_sec),
    .ip_addr_out(), .subnet_out(), .gateway_out(), .dyn_ip_out(dyn), .settings_apply_out(),
    .accuracy_valid_out(acc));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic t_reset();
    check("ct_pri", ct_pri, 12'h005);
    check("ct_sec", sec5, 1'b1);
    check("vt_pri", vt_pri, VT_PRI_RESET);
    check("vt_sec", vt_sec, VT_SEC_RESET);
    check("dyn", dyn, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_enter();
    op.press(2'h3, 130);
    check("prog", prog, 1'b1);
    check("query", pwq, 1'b0);
    check("menu", menu, MENU_CT);
    $display("enter test done");
  endtask : t_enter
  task automatic t_ct_edit();
    op.press(2'h1, 20);
    check("field", field, FLD_PRI);
    check("digit", dig, 2'h0);
    repeat (3) op.press(2'h1, 20);
    check("digit", dig, DIG_ALL);
    op.press(2'h2, 20);
    check("point", dp, 2'h1);
    op.press(2'h1, 20);
    check("field", field, FLD_SEC);
    op.press(2'h2, 20);
    check("ct_sec", sec5, 1'b1);
    op.press(2'h1, 20);
    check("field", field, FLD_NONE);
    $display("ct edit test done");
  endtask : t_ct_edit
  task automatic t_menus();
    for (int i = 1; i < 7; i++) begin
      op.press(2'h2, 20);
      check("menu", menu, i);
    end
    op.press(2'h2, 80);
    check("menu", menu, MENU_GATEWAY);
    $display("menu test done");
  endtask : t_menus
  task automatic t_params();
    repeat (3) op.press(2'h2, 80);
    op.press(2'h1, 20);
    op.press(2'h2, 20);
    repeat (3) op.press(2'h1, 20);
    op.press(2'h2, 20);
    repeat (3) op.press(2'h1, 20);
    check("wdata", pwd, 12'h200);
    check("writes", writes, 1);
    $display("param test done");
  endtask : t_params
  task automatic t_exit();
    op.press(2'h3, 130);
    check("prog", prog, 1'b0);
    check("ct_sec", sec5, 1'b0);
    check("ct_dp", ct_dp, 2'h1);
    $display("exit test done");
  endtask : t_exit
  task automatic t_rotate();
    @(posedge clock_in) rot_en <= 1'b1;
    repeat (250) @(posedge clock_in);
    check("ind", ind, 8'h02);
    rot_en <= 1'b0;
    $display("rotate test done");
  endtask : t_rotate
  task automatic t_idle();
    op.press(2'h3, 130);
    repeat (IDLE - 200) @(posedge clock_in);
    check("prog", prog, 1'b1);
    repeat (400) @(posedge clock_in);
    check("prog", prog, 1'b0);
    $display("idle test done");
  endtask : t_idle
  task automatic t_password();
    @(posedge clock_in) password_set <= 1'b1;
    op.press(2'h3, 130);
    check("query", pwq, 1'b1);
    check("entry", edit, 12'h000);
    op.press(2'h2, 20);
    check("entry", edit, 12'h100);
    repeat (3) op.press(2'h1, 20);
    check("prog", prog, 1'b1);
    check("acc", acc, 1'b1);
    op.press(2'h3, 130);
    $display("password test done");
  endtask : t_password
  initial begin
    repeat (60000) @(posedge clock_in);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    t_reset();
    t_enter();
    t_ct_edit();
    t_menus();
    t_params();
    t_exit();
    t_rotate();
    t_idle();
    t_password();
    report_and_stop();
  end
endmodule : front_panel_menu_control_tb
`default_nettype wire
